// ---- hdl/srs_device.sv ----
// Device end: power-on reset count, boot processor sequence loading the
// auxiliary unit, and the power-on hang that a secondary reset clears.
// Assumes dev_reset_n is a board pin, synchronised here.
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_device #(
  parameter int POR_CYCLES = `SRS_POR_CYCLES,
  parameter int AUX_INSTRUCTION_RAM_DEPTH = `SRS_AUX_INSTRUCTION_RAM_DEPTH,
  parameter int PAD_OPS = `SRS_PAD_OPS,
  parameter bit FIXED_ROM = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  srs_link_if.device link,
  input wire logic bus_garbage_reserved,
  output logic boot_done,
  output logic boot_hung,
  output logic [31:0] boot_pc,
  output logic aux_running
);
  import srs_pkg::*;

  initial begin
    if (POR_CYCLES < 1 || AUX_INSTRUCTION_RAM_DEPTH < 2 || PAD_OPS >= AUX_INSTRUCTION_RAM_DEPTH) begin
      $error("srs_device: bad parameters");
    end
  end

  localparam logic [7:0] OP_NOP = 8'h01;
  localparam logic [7:0] OP_ACK = 8'hA5;
  localparam logic [7:0] OP_RESV = 8'hFF;

  function automatic logic is_reserved(input logic [7:0] op);
    is_reserved = (op == OP_RESV);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Pin synchroniser
  // Only the second flop is read; the board pin is asynchronous
  logic rst_pin_s1_ff, rst_pin_s2_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_pin_s1_ff <= 1'b0;
      rst_pin_s2_ff <= 1'b0;
    end else begin
      rst_pin_s1_ff <= link.dev_reset_n;
      rst_pin_s2_ff <= rst_pin_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Boot state
  srs_dev_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;
  // No reset: words only matter once the boot sequence has loaded them
  logic [7:0] aux_instruction_ram_ff [AUX_INSTRUCTION_RAM_DEPTH];
  logic [7:0] fetch_bus_ff, nxt_fetch_bus;
  // Cleared only by rst, which stands for a power cycle
  logic bus_valid_ff, nxt_bus_valid;
  logic done_tgl_ff, nxt_done_tgl;
  logic boot_done_ff, nxt_boot_done;
  logic aux_run_ff, nxt_aux_run;
  logic [31:0] pc_ff, nxt_pc;
  logic [7:0] load_op;

  // Prefill with harmless opcodes so a misread start still recovers
  always_comb begin
    load_op = (cnt_ff < 16'(PAD_OPS)) ? OP_NOP : OP_ACK;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_fetch_bus = fetch_bus_ff;
    nxt_bus_valid = bus_valid_ff;
    nxt_done_tgl = done_tgl_ff;
    nxt_boot_done = boot_done_ff;
    nxt_aux_run = aux_run_ff;
    nxt_pc = pc_ff;
    if (!rst_pin_s2_ff) begin
      // Held in reset; the fetch bus keeps its content across resets
      nxt_state = SRS_DEV_RESET;
      nxt_cnt = 16'h0000;
      nxt_boot_done = 1'b0;
      nxt_aux_run = 1'b0;
      nxt_pc = 32'h00000000;
    end else begin
      case (state_ff)
        SRS_DEV_RESET: begin
          nxt_state = SRS_DEV_POR;
          nxt_cnt = 16'h0001;
        end
        SRS_DEV_POR: begin
          nxt_cnt = cnt_ff + 16'h0001;
          if (cnt_ff == 16'(POR_CYCLES - 1)) begin
            nxt_done_tgl = ~done_tgl_ff;
            nxt_cnt = 16'h0000;
            nxt_pc = `SRS_ROM_LO;
            nxt_state = SRS_DEV_LOAD;
          end
        end
        SRS_DEV_LOAD: begin
          nxt_cnt = cnt_ff + 16'h0001;
          nxt_pc = `SRS_ROM_LO + 32'(cnt_ff);
          if (cnt_ff == 16'(AUX_INSTRUCTION_RAM_DEPTH - 1)) begin
            nxt_cnt = 16'h0000;
            nxt_state = FIXED_ROM ? SRS_DEV_VERIFY : SRS_DEV_START;
          end
        end
        SRS_DEV_VERIFY: begin
          // Read-back leaves a known word on the fetch bus
          nxt_fetch_bus = aux_instruction_ram_ff[0];
          nxt_bus_valid = 1'b1;
          nxt_state = SRS_DEV_START;
        end
        SRS_DEV_START: begin
          // Reset and enable in one write: no idle decode window
          nxt_aux_run = 1'b1;
          if (!bus_valid_ff && bus_garbage_reserved && !FIXED_ROM) begin
            nxt_state = SRS_DEV_STUCK;
          end else begin
            nxt_state = SRS_DEV_RUN;
          end
          // Core fetched a real word even when it ends up stuck
          nxt_fetch_bus = aux_instruction_ram_ff[0];
          nxt_bus_valid = 1'b1;
        end
        SRS_DEV_RUN: begin
          nxt_boot_done = 1'b1;
          nxt_pc = 32'h80000000;
        end
        SRS_DEV_STUCK: begin
          // Polls for an ack that never comes
          nxt_pc = (pc_ff == `SRS_ROM_HI) ? `SRS_ROM_LO : pc_ff + 32'h00000001;
        end
        default: nxt_state = SRS_DEV_RESET;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= SRS_DEV_RESET;
      cnt_ff <= 16'h0000;
      fetch_bus_ff <= 8'h00;
      bus_valid_ff <= 1'b0;
      done_tgl_ff <= 1'b0;
      boot_done_ff <= 1'b0;
      aux_run_ff <= 1'b0;
      pc_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      fetch_bus_ff <= nxt_fetch_bus;
      bus_valid_ff <= nxt_bus_valid;
      done_tgl_ff <= nxt_done_tgl;
      boot_done_ff <= nxt_boot_done;
      aux_run_ff <= nxt_aux_run;
      pc_ff <= nxt_pc;
    end
  end

  always_ff @(posedge clk) begin
    if (state_ff == SRS_DEV_LOAD && rst_pin_s2_ff) begin
      aux_instruction_ram_ff[cnt_ff[$clog2(AUX_INSTRUCTION_RAM_DEPTH)-1:0]] <= load_op;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs and watchdog service
  // Service toggles on a slow period while booted; a steady level would give
  // the supervisor one edge only, and it would then reset a healthy device
  localparam int SVC_DIV = 8;
  logic hung_ff, nxt_hung;
  logic svc_ff, nxt_svc;
  logic [3:0] svc_cnt_ff, nxt_svc_cnt;

  always_comb begin
    nxt_hung = (state_ff == SRS_DEV_STUCK) && !is_reserved(fetch_bus_ff);
    nxt_svc = svc_ff;
    nxt_svc_cnt = svc_cnt_ff + 4'h1;
    if (!boot_done_ff) begin
      nxt_svc = 1'b0;
      nxt_svc_cnt = 4'h0;
    end else if (svc_cnt_ff == 4'(SVC_DIV - 1)) begin
      nxt_svc = ~svc_ff;
      nxt_svc_cnt = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hung_ff <= 1'b0;
      svc_ff <= 1'b0;
      svc_cnt_ff <= 4'h0;
    end else begin
      hung_ff <= nxt_hung;
      svc_ff <= nxt_svc;
      svc_cnt_ff <= nxt_svc_cnt;
    end
  end

  assign link.reset_done_output = done_tgl_ff;
  assign link.wdog_service = svc_ff;
  assign boot_done = boot_done_ff;
  assign boot_hung = hung_ff;
  assign boot_pc = pc_ff;
  assign aux_running = aux_run_ff;
endmodule // srs_device

// ---- hdl/srs_defs.svh ----
// Timing constants for the secondary reset sequencer pair.
// Assumes a 10 MHz system clock on both ends.
//
// Function
// - Reset-done toggles 6192 cycles after release
// - First release held at least 883us
// - Allow about 15k boot cycles first
// - Secondary reset no sooner than 1ms
// - Stay healthy after secondary reset until power-off
// - Stuck state leaves fetch bus valid
// - Verify instruction RAM before unit reset
// - Reset and enable unit same cycle
// - Prefill instruction RAM with harmless opcodes
// - Failing boot loops in boot ROM
// - Watchdog variant resets on boot failure
// - Watchdog timeout about 200ms
// - Timed pulses: 2ms high, 0.5ms low
// - Secondary reset optional, bypassable
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH
`define SRS_CLK_HZ 10000000
`define SRS_POR_CYCLES 6192
`define SRS_BOOT_CYCLES 15000
`define SRS_FIRST_HIGH_US 2000
`define SRS_MIN_HIGH_US 1000
`define SRS_LOW_US 500
`define SRS_WDOG_MS 200
`define SRS_US_TO_CYC(us) (((us) * (`SRS_CLK_HZ / 1000000)))
`define SRS_ROM_LO 32'h00700000
`define SRS_ROM_HI 32'h007FFFFF
`define SRS_AUX_INSTRUCTION_RAM_DEPTH 16
`define SRS_PAD_OPS 4
`endif

// ---- hdl/srs_pkg.sv ----
// Types shared by both ends of the secondary reset sequencer.
// Assumes srs_defs.svh supplies the numeric constants.
package srs_pkg;
  typedef enum logic [1:0] {
    SRS_GEN_IDLE,
    SRS_GEN_HIGH1,
    SRS_GEN_LOW,
    SRS_GEN_HIGH2
  } srs_gen_state_t;
  typedef enum logic [2:0] {
    SRS_DEV_RESET,
    SRS_DEV_POR,
    SRS_DEV_LOAD,
    SRS_DEV_VERIFY,
    SRS_DEV_START,
    SRS_DEV_RUN,
    SRS_DEV_STUCK
  } srs_dev_state_t;
endpackage

// ---- hdl/srs_link_if.sv ----
// Link between the board reset generator and the device.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface srs_link_if;
  logic dev_reset_n;
  logic reset_done_output;
  logic wdog_service;
  modport device (input dev_reset_n, output reset_done_output, output wdog_service);
  modport generator (output dev_reset_n, input reset_done_output, input wdog_service);
endinterface

// ---- hdl/srs_generator.sv ----
// Board reset generator: timed pulse sequence or watchdog supervisor.
// Assumes board_reset is an asynchronous board level.
`timescale 1ns/1ps
`include "srs_defs.svh"
module srs_generator #(
  parameter int FIRST_HIGH_CYC = `SRS_US_TO_CYC(`SRS_FIRST_HIGH_US),
  parameter int LOW_CYC = `SRS_US_TO_CYC(`SRS_LOW_US),
  parameter int WDOG_CYC = `SRS_WDOG_MS * (`SRS_CLK_HZ / 1000),
  parameter int MIN_HIGH_CYC = `SRS_US_TO_CYC(`SRS_MIN_HIGH_US)
) (
  input wire logic clk,
  input wire logic rst,
  srs_link_if.generator link,
  input wire logic board_reset,
  input wire logic bypass,
  input wire logic use_watchdog,
  output logic seq_done
);
  import srs_pkg::*;

  initial begin
    if (FIRST_HIGH_CYC < MIN_HIGH_CYC || LOW_CYC < 1 || WDOG_CYC < FIRST_HIGH_CYC) begin
      $error("srs_generator: bad parameters");
    end
  end

  ////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [2:0] s1_ff, s2_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
    end else begin
      s1_ff <= {link.wdog_service, bypass, board_reset};
      s2_ff <= s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer
  srs_gen_state_t state_ff, nxt_state;
  logic [31:0] cnt_ff, nxt_cnt;
  logic out_ff, nxt_out;
  logic done_ff, nxt_done;
  logic svc_d_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 32'h00000001;
    nxt_out = out_ff;
    nxt_done = done_ff;
    if (!s2_ff[0]) begin
      nxt_state = SRS_GEN_IDLE;
      nxt_cnt = 32'h00000000;
      nxt_out = 1'b0;
      nxt_done = 1'b0;
    end else begin
      case (state_ff)
        SRS_GEN_IDLE: begin
          nxt_state = SRS_GEN_HIGH1;
          nxt_out = 1'b1;
          nxt_cnt = 32'h00000000;
          nxt_done = s2_ff[1];
          if (s2_ff[1]) begin
            nxt_state = SRS_GEN_HIGH2;
          end
        end
        SRS_GEN_HIGH1: begin
          // Long enough for POR plus boot cycles to fetch a word
          if (!use_watchdog && cnt_ff >= 32'(FIRST_HIGH_CYC - 1)) begin
            nxt_state = SRS_GEN_LOW;
            nxt_out = 1'b0;
            nxt_cnt = 32'h00000000;
          end else if (use_watchdog && s2_ff[2] != svc_d_ff) begin
            nxt_cnt = 32'h00000000;
          end else if (use_watchdog && cnt_ff >= 32'(WDOG_CYC - 1)) begin
            nxt_state = SRS_GEN_LOW;
            nxt_out = 1'b0;
            nxt_cnt = 32'h00000000;
          end
        end
        SRS_GEN_LOW: begin
          if (cnt_ff >= 32'(LOW_CYC - 1)) begin
            nxt_state = use_watchdog ? SRS_GEN_HIGH1 : SRS_GEN_HIGH2;
            nxt_out = 1'b1;
            nxt_cnt = 32'h00000000;
            nxt_done = !use_watchdog;
          end
        end
        SRS_GEN_HIGH2: begin
          nxt_cnt = cnt_ff;
        end
        default: nxt_state = SRS_GEN_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= SRS_GEN_IDLE;
      cnt_ff <= 32'h00000000;
      out_ff <= 1'b0;
      done_ff <= 1'b0;
      svc_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
      done_ff <= nxt_done;
      svc_d_ff <= s2_ff[2];
    end
  end

  assign link.dev_reset_n = out_ff;
  assign seq_done = done_ff;
endmodule // srs_generator

// ---- verification/srs_chk.sv ----
// Link checker for the reset generator and device pair.
// Assumes the bench places it beside srs_link_if on the shared clock.
`timescale 1ns/1ps
// Defaults follow the bench's shortened counts, so the bench needs no overrides here
module srs_chk #(
  parameter int POR_CYCLES = 100,
  parameter int MIN_HIGH_CYC = 200,
  parameter int LOW_CYC = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic dev_reset_n,
  input wire logic reset_done_output,
  input wire logic wdog_service
);
  localparam int DONE_LO = POR_CYCLES;
  localparam int DONE_HI = POR_CYCLES + 8;
  logic [31:0] hi_cnt_ff, nxt_hi_cnt, lo_cnt_ff, nxt_lo_cnt;
  logic fell_ff, nxt_fell;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // The power-on low has no set length, so low width counts only after a seen fall
  always_comb begin
    nxt_hi_cnt = dev_reset_n ? hi_cnt_ff + 32'h1 : 32'h0;
    nxt_lo_cnt = dev_reset_n ? 32'h0 : lo_cnt_ff + 32'h1;
    nxt_fell = fell_ff | (!dev_reset_n && hi_cnt_ff != 32'h0);
  end
  always_ff @(posedge clk) begin
    hi_cnt_ff <= rst ? 32'h0 : nxt_hi_cnt;
    lo_cnt_ff <= rst ? 32'h0 : nxt_lo_cnt;
    fell_ff <= rst ? 1'b0 : nxt_fell;
  end
  ////////////////////////////////////////////////////////////
  done_delay_a: assert property ($rose(dev_reset_n) |-> ##[DONE_LO:DONE_HI] $changed(reset_done_output))
    else $error("reset done late or missing");
  done_quiet_a: assert property ($rose(dev_reset_n) |=> $stable(reset_done_output) [*8])
    else $error("reset done toggled early");
  done_in_run_a: assert property ($changed(reset_done_output) |-> dev_reset_n)
    else $error("reset done toggled while in reset");
  first_high_a: assert property ($fell(dev_reset_n) |-> hi_cnt_ff >= MIN_HIGH_CYC)
    else $error("secondary reset too soon");
  low_width_a: assert property ($rose(dev_reset_n) && fell_ff |-> lo_cnt_ff == LOW_CYC)
    else $error("reset low width wrong");
  low_hold_a: assert property ($fell(dev_reset_n) |=> !dev_reset_n [*8])
    else $error("reset low glitch");
  service_drop_a: assert property ($fell(dev_reset_n) |-> ##[1:4] !wdog_service)
    else $error("service kept through reset");
  service_late_a: assert property ($rose(wdog_service) |-> hi_cnt_ff > POR_CYCLES)
    else $error("service before boot");
  rel_c: cover property ($rose(dev_reset_n));
  pulse_c: cover property ($fell(dev_reset_n));
  boot_c: cover property ($rose(wdog_service));
endmodule // srs_chk

// ---- verification/secondary_reset_sequencer_tb.sv ----
// Bench joining generator and device through srs_link_if.
// Assumes the shortened counts set on the instances below.
`timescale 1ns/1ps
module secondary_reset_sequencer_tb;
  import srs_pkg::*;
  typedef struct {logic g, b, w, done, hung;} srs_row_t;
  logic clk = 1'b0, rst = 1'b1, board_reset = 1'b0, bypass = 1'b0, use_watchdog = 1'b0, garbage = 1'b0;
  logic seq_done, boot_done, boot_hung, aux_running;
  logic [31:0] boot_pc;
  int n_mismatch = 0, checks = 0, hi, lo, n;
  srs_row_t rows[5] = '{'{0, 0, 0, 1, 0}, '{1, 0, 0, 1, 0}, '{1, 1, 0, 0, 1}, '{0, 1, 0, 1, 0}, '{1, 0, 1, 1, 0}};
  always #50 clk = ~clk;
  srs_link_if srs_link_if_i();
  srs_generator #(.FIRST_HIGH_CYC(300), .LOW_CYC(50), .WDOG_CYC(400), .MIN_HIGH_CYC(200)) srs_generator_i (
    .clk(clk), .rst(rst), .link(srs_link_if_i), .board_reset(board_reset), .bypass(bypass),
    .use_watchdog(use_watchdog), .seq_done(seq_done));
  srs_device #(.POR_CYCLES(100)) srs_device_i (
    .clk(clk), .rst(rst), .link(srs_link_if_i), .bus_garbage_reserved(garbage), .boot_done(boot_done),
    .boot_hung(boot_hung), .boot_pc(boot_pc), .aux_running(aux_running));
  srs_chk srs_chk_i (
    .clk(clk), .rst(rst), .dev_reset_n(srs_link_if_i.dev_reset_n),
    .reset_done_output(srs_link_if_i.reset_done_output), .wdog_service(srs_link_if_i.wdog_service));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // Power cycle: rst wipes the fetch bus, so each case starts from a cold boot
  task automatic power_up(input logic g, input logic b, input logic w);
    @(posedge clk);
    rst <= 1'b1;
    board_reset <= 1'b0;
    garbage <= g;
    bypass <= b;
    use_watchdog <= w;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    board_reset <= 1'b1;
  endtask
  task automatic run_len(input logic lvl, output int cnt);
    cnt = 0;
    while (srs_link_if_i.dev_reset_n === lvl && cnt < 5000) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #3000000;
    n_mismatch++;
    summarize();
  end
  initial begin
    foreach (rows[i]) begin
      power_up(rows[i].g, rows[i].b, rows[i].w);
      repeat (1500) @(posedge clk);
      #1;
      chk("boot_done", {31'h0, rows[i].done}, {31'h0, boot_done});
      chk("boot_hung", {31'h0, rows[i].hung}, {31'h0, boot_hung});
      chk("aux_running", 32'h1, {31'h0, aux_running});
      if (!rows[i].w) begin
        chk("seq_done", 32'h1, {31'h0, seq_done});
      end
      if (rows[i].hung) begin
        chk("pc_in_rom", 32'h1, {31'h0, boot_pc >= 32'h00700000 && boot_pc <= 32'h007FFFFF});
      end
    end
    // Pulse shape of the timed variant, measured on the wire
    power_up(1'b1, 1'b0, 1'b0);
    @(posedge clk);
    #1;
    chk("boot_done_rst", 32'h0, {31'h0, boot_done});
    chk("reset_done_output", 32'h0, {31'h0, srs_link_if_i.reset_done_output});
    run_len(1'b0, n);
    run_len(1'b1, hi);
    run_len(1'b0, lo);
    chk("first_high", 32'd300, hi);
    chk("low_time", 32'd50, lo);
    repeat (400) @(posedge clk);
    #1;
    chk("dev_reset_n", 32'h1, {31'h0, srs_link_if_i.dev_reset_n});
    // Watchdog variant: one timeout on the stuck boot, then service keeps it quiet
    power_up(1'b1, 1'b0, 1'b1);
    @(posedge clk);
    #1;
    run_len(1'b0, n);
    run_len(1'b1, hi);
    run_len(1'b0, lo);
    chk("wdog_timeout", 32'd400, hi);
    chk("wdog_low", 32'd50, lo);
    run_len(1'b1, hi);
    chk("wdog_kept", 32'd5000, hi);
    chk("boot_done_wdog", 32'h1, {31'h0, boot_done});
    summarize();
  end
endmodule // secondary_reset_sequencer_tb
